// [include/dttc_map.svh]
// register offsets, field positions and reset values of the timer bank
`ifndef DTTC_MAP_SVH
`define DTTC_MAP_SVH
`define DTTC_BANK_D 4'hD
`define DTTC_OFF_BYTE_CTRL 4'h0
`define DTTC_OFF_SHARED_CTRL 4'h1
`define DTTC_OFF_WORD_CTRL 4'h2
`define DTTC_OFF_BYTE_HIGH 4'h4
`define DTTC_OFF_BYTE_LOW 4'h5
`define DTTC_OFF_WORD_LOW 4'h6
`define DTTC_OFF_WORD_HIGH 4'h7
`define DTTC_OFF_WCAP_LOW 4'h8
`define DTTC_OFF_WCAP_HIGH 4'h9
`define DTTC_OFF_BCAP_LOW 4'hA
`define DTTC_OFF_BCAP_HIGH 4'hB
`define DTTC_BIT_ENABLE 7
`define DTTC_BIT_SINGLE 6
`define DTTC_BIT_STATUS 5
`define DTTC_BIT_IRQ_EN 1
`define DTTC_BIT_DEMOD 7
`define DTTC_BIT_BYTE_INIT 1
`define DTTC_BIT_WORD_INIT 0
`define DTTC_RST_BYTE 8'h00
`define DTTC_RST_WORD 16'h0000
`endif

// [include/dttc_pkg.sv]
// types shared by the dual timer block
package dttc_pkg;
  typedef enum logic [1:0] {
    DTTC_IDLE = 2'b01,
    DTTC_RUN = 2'b10
  } dttc_state_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } dttc_req_type;
endpackage

// [hdl/dttc_top.sv]
// dual timer: byte timer transmit, word timer transmit, capture registers
`timescale 1ns/1ps
`include "dttc_map.svh"

// Contract
// - enable drives initial level, loads matching reload
// - single pass: stop, toggle, status, optional irq
// - byte modulo first terminal count toggles without irq; word modulo raises status and irq at every terminal count
// - byte modulo reloads by level, word modulo reloads its one value; toggles, status, irq
// - reload writes reach counter only at load
// - count zero wraps for full period
// - byte capture high counts ones, low zeros
// - word capture split into high, low bytes
// - registers reached only through bank D
// - word timer loads high*256 plus low
// - mode bit picks transmit or demodulation
module dttc_top (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] register_pointer_i,
  input wire dttc_pkg::dttc_req_type req_i,
  input wire logic measured_i,
  output logic [7:0] rdata_o,
  output logic byte_timer_output_o,
  output logic word_timer_output_o,
  output logic byte_irq_o,
  output logic word_irq_o
);
  dttc_pkg::dttc_state_type bst_q, bst_d, wst_q, wst_d;
  logic [7:0] bctl_q, bctl_d, sctl_q, sctl_d, wctl_q, wctl_d;
  logic [7:0] bhi_q, bhi_d, blo_q, blo_d, whi_q, whi_d, wlo_q, wlo_d;
  logic [7:0] bcnt_q, bcnt_d;
  logic [15:0] wcnt_q, wcnt_d;
  logic bout_q, bout_d, wout_q, wout_d, first_q, first_d;
  logic birq_q, birq_d, wirq_q, wirq_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] bcap_hi_q, bcap_hi_d, bcap_lo_q, bcap_lo_d;
  logic [15:0] wcap_q, wcap_d, mcnt_q, mcnt_d;
  logic [7:0] bmcnt_q, bmcnt_d;
  logic sync1_q, sync2_q, sync3_q;
  logic bank_ok, wr_ok, rd_ok, demod;
  logic bstart, wstart, bzero, wzero;
  logic bclr, wclr;

  assign bank_ok = register_pointer_i[3:0] == `DTTC_BANK_D;
  assign wr_ok = req_i.wr && bank_ok;
  assign rd_ok = req_i.rd && bank_ok;
  assign demod = sctl_q[`DTTC_BIT_DEMOD];

  always_comb begin
    bctl_d = bctl_q;
    sctl_d = sctl_q;
    wctl_d = wctl_q;
    bhi_d = bhi_q;
    blo_d = blo_q;
    whi_d = whi_q;
    wlo_d = wlo_q;
    bcnt_d = bcnt_q;
    wcnt_d = wcnt_q;
    bout_d = bout_q;
    wout_d = wout_q;
    first_d = first_q;
    bst_d = bst_q;
    wst_d = wst_q;
    birq_d = 1'b0;
    wirq_d = 1'b0;
    rdata_d = rdata_q;
    bstart = 1'b0;
    wstart = 1'b0;
    bclr = 1'b0;
    wclr = 1'b0;
    // reload writes land in holding registers only
    if (wr_ok) begin
      case (req_i.addr)
        `DTTC_OFF_BYTE_CTRL: begin
          bstart = req_i.wdata[`DTTC_BIT_ENABLE] &&
                   !bctl_q[`DTTC_BIT_ENABLE];
          bclr = req_i.wdata[`DTTC_BIT_STATUS];
          bctl_d = {req_i.wdata[7:6], bctl_q[5], req_i.wdata[4:0]};
        end
        `DTTC_OFF_SHARED_CTRL: sctl_d = req_i.wdata;
        `DTTC_OFF_WORD_CTRL: begin
          wstart = req_i.wdata[`DTTC_BIT_ENABLE] &&
                   !wctl_q[`DTTC_BIT_ENABLE];
          wclr = req_i.wdata[`DTTC_BIT_STATUS];
          wctl_d = {req_i.wdata[7:6], wctl_q[5], req_i.wdata[4:0]};
        end
        `DTTC_OFF_BYTE_HIGH: bhi_d = req_i.wdata;
        `DTTC_OFF_BYTE_LOW: blo_d = req_i.wdata;
        `DTTC_OFF_WORD_LOW: wlo_d = req_i.wdata;
        `DTTC_OFF_WORD_HIGH: whi_d = req_i.wdata;
        default: ;
      endcase
    end
    // status clear is write-one; a same-cycle set below wins
    if (bclr) begin
      bctl_d[`DTTC_BIT_STATUS] = 1'b0;
    end
    if (wclr) begin
      wctl_d[`DTTC_BIT_STATUS] = 1'b0;
    end
    if (wr_ok && req_i.addr == `DTTC_OFF_BYTE_CTRL &&
        !req_i.wdata[`DTTC_BIT_ENABLE]) begin
      bst_d = dttc_pkg::DTTC_IDLE;
    end
    if (wr_ok && req_i.addr == `DTTC_OFF_WORD_CTRL &&
        !req_i.wdata[`DTTC_BIT_ENABLE]) begin
      wst_d = dttc_pkg::DTTC_IDLE;
    end

    // byte timer; a count of one is never programmed by software
    // zero wraps through FF, so an initial zero gives 256 steps
    bzero = (bst_q == dttc_pkg::DTTC_RUN) && (bcnt_q == 8'h01);
    case (bst_q)
      dttc_pkg::DTTC_IDLE: ;
      dttc_pkg::DTTC_RUN: begin
        bcnt_d = bcnt_q - 8'h01;
        if (bzero) begin
          bout_d = !bout_q;
          if (bctl_q[`DTTC_BIT_SINGLE]) begin
            bst_d = dttc_pkg::DTTC_IDLE;
            bctl_d[`DTTC_BIT_ENABLE] = 1'b0;
            bctl_d[`DTTC_BIT_STATUS] = 1'b1;
            birq_d = bctl_q[`DTTC_BIT_IRQ_EN];
          end else begin
            bcnt_d = bout_q ? blo_q : bhi_q;
            first_d = 1'b0;
            if (!first_q) begin
              bctl_d[`DTTC_BIT_STATUS] = 1'b1;
              birq_d = bctl_q[`DTTC_BIT_IRQ_EN];
            end
          end
        end
      end
      default: bst_d = dttc_pkg::DTTC_IDLE;
    endcase
    if (bstart && !demod) begin
      bst_d = dttc_pkg::DTTC_RUN;
      bout_d = sctl_q[`DTTC_BIT_BYTE_INIT];
      bcnt_d = sctl_q[`DTTC_BIT_BYTE_INIT] ? bhi_q : blo_q;
      first_d = 1'b1;
    end

    // word timer, single reload value in both modes
    wzero = (wst_q == dttc_pkg::DTTC_RUN) && (wcnt_q == 16'h0001);
    case (wst_q)
      dttc_pkg::DTTC_IDLE: ;
      dttc_pkg::DTTC_RUN: begin
        wcnt_d = wcnt_q - 16'h0001;
        if (wzero) begin
          wout_d = !wout_q;
          wctl_d[`DTTC_BIT_STATUS] = 1'b1;
          wirq_d = wctl_q[`DTTC_BIT_IRQ_EN];
          if (wctl_q[`DTTC_BIT_SINGLE]) begin
            wst_d = dttc_pkg::DTTC_IDLE;
            wctl_d[`DTTC_BIT_ENABLE] = 1'b0;
          end else begin
            wcnt_d = {whi_q, wlo_q};
          end
        end
      end
      default: wst_d = dttc_pkg::DTTC_IDLE;
    endcase
    if (wstart && !demod) begin
      wst_d = dttc_pkg::DTTC_RUN;
      wout_d = sctl_q[`DTTC_BIT_WORD_INIT];
      wcnt_d = {whi_q, wlo_q};
    end

    if (rd_ok) begin
      case (req_i.addr)
        `DTTC_OFF_BYTE_CTRL: rdata_d = bctl_q;
        `DTTC_OFF_SHARED_CTRL: rdata_d = sctl_q;
        `DTTC_OFF_WORD_CTRL: rdata_d = wctl_q;
        `DTTC_OFF_BYTE_HIGH: rdata_d = bhi_q;
        `DTTC_OFF_BYTE_LOW: rdata_d = blo_q;
        `DTTC_OFF_WORD_LOW: rdata_d = wlo_q;
        `DTTC_OFF_WORD_HIGH: rdata_d = whi_q;
        `DTTC_OFF_WCAP_LOW: rdata_d = wcap_q[7:0];
        `DTTC_OFF_WCAP_HIGH: rdata_d = wcap_q[15:8];
        `DTTC_OFF_BCAP_LOW: rdata_d = bcap_lo_q;
        `DTTC_OFF_BCAP_HIGH: rdata_d = bcap_hi_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bst_q <= dttc_pkg::DTTC_IDLE;
      wst_q <= dttc_pkg::DTTC_IDLE;
      bctl_q <= `DTTC_RST_BYTE;
      sctl_q <= `DTTC_RST_BYTE;
      wctl_q <= `DTTC_RST_BYTE;
      bhi_q <= `DTTC_RST_BYTE;
      blo_q <= `DTTC_RST_BYTE;
      whi_q <= `DTTC_RST_BYTE;
      wlo_q <= `DTTC_RST_BYTE;
      bcnt_q <= `DTTC_RST_BYTE;
      wcnt_q <= `DTTC_RST_WORD;
      bout_q <= 1'b0;
      wout_q <= 1'b0;
      first_q <= 1'b0;
      birq_q <= 1'b0;
      wirq_q <= 1'b0;
      rdata_q <= `DTTC_RST_BYTE;
    end else begin
      bst_q <= bst_d;
      wst_q <= wst_d;
      bctl_q <= bctl_d;
      sctl_q <= sctl_d;
      wctl_q <= wctl_d;
      bhi_q <= bhi_d;
      blo_q <= blo_d;
      whi_q <= whi_d;
      wlo_q <= wlo_d;
      bcnt_q <= bcnt_d;
      wcnt_q <= wcnt_d;
      bout_q <= bout_d;
      wout_q <= wout_d;
      first_q <= first_d;
      birq_q <= birq_d;
      wirq_q <= wirq_d;
      rdata_q <= rdata_d;
    end
  end

  // capture: measure each level run of the synced input
  always_comb begin
    bcap_hi_d = bcap_hi_q;
    bcap_lo_d = bcap_lo_q;
    wcap_d = wcap_q;
    bmcnt_d = bmcnt_q + 8'h01;
    mcnt_d = mcnt_q + 16'h0001;
    if (!demod) begin
      bmcnt_d = 8'h00;
      mcnt_d = 16'h0000;
    end else if (sync2_q != sync3_q) begin
      if (sync3_q) begin
        bcap_hi_d = bmcnt_q;
      end else begin
        bcap_lo_d = bmcnt_q;
      end
      wcap_d = mcnt_q;
      // the edge cycle already belongs to the next run
      bmcnt_d = 8'h01;
      mcnt_d = 16'h0001;
    end
  end

  // counters wrap on overlong runs; no saturation kept for area
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      bcap_hi_q <= `DTTC_RST_BYTE;
      bcap_lo_q <= `DTTC_RST_BYTE;
      wcap_q <= `DTTC_RST_WORD;
      bmcnt_q <= `DTTC_RST_BYTE;
      mcnt_q <= `DTTC_RST_WORD;
    end else begin
      sync1_q <= measured_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      bcap_hi_q <= bcap_hi_d;
      bcap_lo_q <= bcap_lo_d;
      wcap_q <= wcap_d;
      bmcnt_q <= bmcnt_d;
      mcnt_q <= mcnt_d;
    end
  end

  assign rdata_o = rdata_q;
  assign byte_timer_output_o = bout_q;
  assign word_timer_output_o = wout_q;
  assign byte_irq_o = birq_q;
  assign word_irq_o = wirq_q;
endmodule

// [tb/dttc_top_asserts.sv]
// port checker for the dual timer block
`timescale 1ns/1ps
module dttc_top_asserts (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] register_pointer_i,
  input wire dttc_pkg::dttc_req_type req_i,
  input wire logic measured_i,
  input wire logic [7:0] rdata_o,
  input wire logic byte_timer_output_o,
  input wire logic word_timer_output_o,
  input wire logic byte_irq_o,
  input wire logic word_irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic sel;
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  assign sel = register_pointer_i[3:0] == 4'hD;
  always_comb begin
    hi_d = hi_q;
    if (req_i.wr && sel && req_i.addr == 4'h4) hi_d = req_i.wdata;
  end
  // shadow of the high reload, to judge read-back
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) hi_q <= 8'h00;
    else hi_q <= hi_d;
  end
  byte_irq_pulse_a: assert property (byte_irq_o |=> !byte_irq_o)
    else $error("byte irq longer than one cycle");
  word_irq_pulse_a: assert property (word_irq_o |=> !word_irq_o)
    else $error("word irq longer than one cycle");
  byte_irq_toggle_a: assert property (byte_irq_o |->
    byte_timer_output_o != $past(byte_timer_output_o))
    else $error("byte irq without output toggle");
  word_irq_toggle_a: assert property (word_irq_o |->
    word_timer_output_o != $past(word_timer_output_o))
    else $error("word irq without output toggle");
  other_bank_a: assert property (!(req_i.rd && sel) |=> $stable(rdata_o))
    else $error("read data moved without a bank D read");
  unmapped_zero_a: assert property (req_i.rd && sel &&
    (req_i.addr == 4'h3 || req_i.addr > 4'hB) |=> rdata_o == 8'h00)
    else $error("unmapped offset read not zero");
  high_reload_a: assert property (req_i.rd && sel &&
    req_i.addr == 4'h4 |=> rdata_o == $past(hi_q))
    else $error("high reload read-back wrong");
  byte_out_hold_a: assert property ($changed(byte_timer_output_o)
    |=> $stable(byte_timer_output_o))
    else $error("byte output toggled on consecutive cycles");
endmodule
bind dttc_top dttc_top_asserts i_dttc_top_asserts (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .register_pointer_i(register_pointer_i), .req_i(req_i),
  .measured_i(measured_i), .rdata_o(rdata_o),
  .byte_timer_output_o(byte_timer_output_o),
  .word_timer_output_o(word_timer_output_o),
  .byte_irq_o(byte_irq_o), .word_irq_o(word_irq_o));

// [tb/test_dttc_top.sv]
// self-checking bench for the dual timer block
`timescale 1ns/1ps
module test_dttc_top;
  logic ref_clk_i = 1'h0, rst_i = 1'h1, measured_i = 1'h0;
  logic [7:0] ptr = 8'h0D;
  dttc_pkg::dttc_req_type req = '0;
  logic [7:0] rdata_o;
  logic bo, wo, bi, wi;
  int n_fail = 0, samples_checked = 0;
  logic [15:0] lf = 16'hD5C0;
  // mirror of the plain read/write registers of bank D
  int mdl [16];
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // byte period: level picks the reload, zero means a full 256
  function automatic int span(input logic lvl);
    int v;
    v = lvl ? mdl[4] : mdl[5];
    return (v == 0) ? 256 : v;
  endfunction
  dttc_top i_dttc_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .register_pointer_i(ptr), .req_i(req), .measured_i(measured_i),
    .rdata_o(rdata_o), .byte_timer_output_o(bo),
    .word_timer_output_o(wo), .byte_irq_o(bi), .word_irq_o(wi));
  initial begin
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i); #1;
    req = '{1'b1, 1'b0, a, d};
    @(posedge ref_clk_i); #1;
    req = '0;
    if (ptr[3:0] == 4'hD) mdl[a] = int'(d);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i); #1;
    req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk_i); #1;
    req = '0;
    @(posedge ref_clk_i); #1;
    chk({8'h00, rdata_o}, {8'h00, exp});
  endtask
  // edges until the chosen output moves, and the irq seen with it
  task watch(input logic w, input int gap, input logic irq);
    logic o;
    int n;
    o = w ? wo : bo;
    n = 0;
    do begin
      @(posedge ref_clk_i); #1;
      n++;
    end while ((w ? wo : bo) === o && n < 600);
    chk(16'(n), 16'(gap));
    chk({15'h0, w ? wi : bi}, {15'h0, irq});
  endtask
  task single(input logic init, input logic [7:0] n, input logic ie);
    wr(4'h1, {6'h0, init, 1'b0});
    wr(4'h4, init ? n : 8'h2F);
    wr(4'h5, init ? 8'h2F : n);
    wr(4'h0, {6'h30, ie, 1'b0});
    watch(1'b0, span(init), ie);
    rd(4'h0, {6'h18, ie, 1'b0});
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge ref_clk_i);
    #1 rst_i = 1'h0;
    for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00);
    $display("test reset values done");
    lf = lfsr_next(lf);
    single(1'b0, 8'h03, 1'b1);
    single(1'b1, {3'h0, lf[4:0]} + 8'h02, 1'b1);
    single(1'b0, 8'h00, 1'b0);
    wr(4'h0, 8'h20);
    rd(4'h0, 8'h00);
    $display("test single pass done");
    wr(4'h1, 8'h03);
    wr(4'h4, 8'h0A);
    wr(4'h5, 8'h04);
    wr(4'h0, 8'h82);
    fork
      watch(1'b0, span(1'b1), 1'b0);
      begin
        // lands well clear of the low reload
        repeat (2) @(posedge ref_clk_i);
        wr(4'h5, 8'h06);
      end
    join
    watch(1'b0, span(1'b0), 1'b1);
    watch(1'b0, span(1'b1), 1'b1);
    wr(4'h0, 8'h00);
    $display("test modulo done");
    wr(4'h7, 8'h01);
    wr(4'h6, 8'h05);
    wr(4'h2, 8'hC2);
    chk({15'h0, wo}, 16'h0001);
    chk({15'h0, wi}, 16'h0000);
    watch(1'b1, mdl[7] * 256 + mdl[6], 1'b1);
    rd(4'h2, 8'h62);
    wr(4'h2, 8'h82);
    watch(1'b1, mdl[7] * 256 + mdl[6], 1'b1);
    watch(1'b1, mdl[7] * 256 + mdl[6], 1'b1);
    wr(4'h2, 8'h00);
    $display("test word timer done");
    ptr = 8'h7E;
    wr(4'h4, 8'h11);
    ptr = 8'h7D;
    rd(4'h4, 8'h0A);
    wr(4'h5, lf[7:0]);
    rd(4'h5, lf[7:0]);
    wr(4'hB, 8'h55);
    rd(4'hB, 8'h00);
    $display("test bank access done");
    wr(4'h1, 8'h80);
    @(posedge ref_clk_i);
    #1 measured_i = 1'h1;
    repeat (20) @(posedge ref_clk_i);
    #1 measured_i = 1'h0;
    repeat (300) @(posedge ref_clk_i);
    #1 measured_i = 1'h1;
    repeat (8) @(posedge ref_clk_i);
    rd(4'hB, 8'h14);
    rd(4'hA, 8'h2C);
    rd(4'h9, 8'h01);
    rd(4'h8, 8'h2C);
    $display("test capture done");
    end_of_test();
  end
endmodule
